// ### pcs_consts.svh
// Timing counts and widths of the configuration stream sequencer
//------------------------------------------------------------------------------
// Overview of operation
// RL1 - After the stream completes, the data outputs stay actively driven low.
// RL2 - The PLD needs a fixed number of clock cycles after done (40, 136 or 10), so the clock runs on.
// RL3 - The power-on hold lasts 2 ms or 100 ms by pin, with the hold line driven low throughout.
// RL4 - The first configuration clock edge comes at least 40 us after the hold line goes high.
// RL5 - The first data is presented at least 40 us after the hold line goes high.
// RL6 - A low hold line during configuration stops the clock after at least 277 ns.
// RL7 - A low hold line during configuration stops the data drive after at least 277 ns.
// RL8 - An outside agent resets the sequencer by holding the hold line low for at least 60 ns.
// RL9 - The done check acts on the hold line at least 60 ns after a clock rising edge.
// RL10 - The generated clock has a period of at least 15 ns and phases of at least 6 ns each.
// RL11 - An external clock source stays at or below 133 MHz with phases of at least 3.375 ns.
// RL12 - After releasing the hold line, the sequencer waits until the line is really high.
// RL13 - The data outputs change on each rising edge of the generated clock.
//------------------------------------------------------------------------------
`ifndef PCS_CONSTS_SVH
`define PCS_CONSTS_SVH

`define PCS_CLK_NS        25
`define PCS_POR_SHORT_MS  2
`define PCS_POR_LONG_MS   100
`define PCS_POR_SHORT_CYC (`PCS_POR_SHORT_MS * 1000000 / `PCS_CLK_NS)
`define PCS_POR_LONG_CYC  (`PCS_POR_LONG_MS * 1000000 / `PCS_CLK_NS)
`define PCS_TCE_NS        40000
`define PCS_TCE_CYC       ((`PCS_TCE_NS + `PCS_CLK_NS - 1) / `PCS_CLK_NS)
`define PCS_TDF_NS        277
`define PCS_TDF_CYC       ((`PCS_TDF_NS + `PCS_CLK_NS - 1) / `PCS_CLK_NS)
`define PCS_TRE_NS        60
`define PCS_TRE_CYC       ((`PCS_TRE_NS + `PCS_CLK_NS - 1) / `PCS_CLK_NS)
`define PCS_USER_CYC      40
`define PCS_CLK_HALF_CYC  3
`define PCS_CHECK_EDGES   4
`define PCS_ERR_HOLD_CYC  4
`define PCS_WORD_W        8

`endif

// ### pcs_pkg.sv
// Types shared by the configuration stream sequencer
package pcs_pkg;
    `include "pcs_consts.svh"

    typedef enum logic [3:0] {
        S_POR, S_WAIT_HIGH, S_SETUP, S_STREAM, S_CHECK, S_USER, S_IDLE, S_ABORT, S_ERR
    } pcs_state_t;

    typedef struct packed {
        logic                   last;
        logic [`PCS_WORD_W-1:0] data;
    } pcs_word_t;

    typedef struct packed {
        logic por_long_sel;
        logic ext_clk_sel;
        logic hold_line;
        logic done_sense_input;
        logic external_clock_input;
    } pcs_pins_t;
endpackage

// ### pcs_sync.sv
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pcs_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic         clk_en,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            meta_r <= '0;
            q      <= '0;
        end else if (clk_en) begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule // pcs_sync

// ### pcs_sequencer.sv
// Configuration stream sequencer: power-on hold, clock and data drive, done check
`timescale 1ns/1ps
`include "pcs_consts.svh"
module pcs_sequencer #(
    parameter int unsigned POR_SHORT_CYC = `PCS_POR_SHORT_CYC,
    parameter int unsigned POR_LONG_CYC  = `PCS_POR_LONG_CYC,
    parameter int unsigned USER_CYC      = `PCS_USER_CYC,
    parameter int unsigned CLK_HALF_CYC  = `PCS_CLK_HALF_CYC,
    parameter int unsigned CHECK_EDGES   = `PCS_CHECK_EDGES,
    parameter int unsigned ERR_HOLD_CYC  = `PCS_ERR_HOLD_CYC,
    parameter int unsigned DATA_W        = `PCS_WORD_W
) (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              clk_en,
    input  wire logic              por_long_sel,
    input  wire logic              ext_clk_sel,
    input  wire logic              external_clock_input,
    input  wire logic              hold_line_in,
    input  wire logic              done_sense_input,
    input  wire logic              src_valid,
    input  wire pcs_pkg::pcs_word_t src_word,
    output logic                   src_ready,
    output logic                   config_clock_out,
    output logic [DATA_W-1:0]      config_data,
    output logic                   config_data_oe,
    output logic                   hold_line_out,
    output logic                   hold_line_oe,
    output logic                   config_done,
    output logic                   done_error
);
    import pcs_pkg::*;

    localparam int TCE_CYC = `PCS_TCE_CYC;
    localparam int TDF_CYC = `PCS_TDF_CYC;
    localparam int TRE_CYC = `PCS_TRE_CYC;

    // The done check decides one cycle after its count ends, so a clock period must be
    // longer than that or the next rise lands on the hold line action [RL9]
    if ((DATA_W != 1 && DATA_W != 2 && DATA_W != 4 && DATA_W != 8) || CLK_HALF_CYC < 1
        || 2 * CLK_HALF_CYC <= TRE_CYC + 1 || USER_CYC < 1 || CHECK_EDGES < 1
        || ERR_HOLD_CYC < 1 || POR_SHORT_CYC < 1 || POR_LONG_CYC < 1
        || USER_CYC > 255 || CHECK_EDGES > 255) begin : g_bad_param
        $error("pcs_sequencer: unsupported parameter values");
    end

    //--------------------------------------------------------------------------
    // Pin synchronisers
    //--------------------------------------------------------------------------
    pcs_pins_t pins_raw;
    pcs_pins_t pins_s;
    assign pins_raw = '{por_long_sel, ext_clk_sel, hold_line_in, done_sense_input,
                        external_clock_input};

    // A synchronised low, however short, in setup, stream, check, user or idle counts as a reset request [RL8]
    pcs_sync #(.W($bits(pcs_pins_t))) u_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .clk_en  (clk_en),
        .d       (pins_raw),
        .q       (pins_s)
    );

    //--------------------------------------------------------------------------
    // State and counters
    //--------------------------------------------------------------------------
    pcs_state_t      state_r, state_nxt;
    logic [31:0]     tcnt_r;
    logic [31:0]     div_r;
    logic [7:0]      edge_r;
    logic [1:0]      since_r;
    logic            pend_r;
    logic            ext_prev_r;
    logic            stage_v_r, stage_v_nxt;
    pcs_word_t       stage_r;
    logic [31:0]     setup_age_r;

    wire hold_hi   = pins_s.hold_line;
    wire done_hi   = pins_s.done_sense_input;
    wire state_chg = (state_nxt != state_r);
    wire [31:0] por_lim = pins_s.por_long_sel ? POR_LONG_CYC : POR_SHORT_CYC;

    // Clock edge sources: divided reference or sampled external clock [RL11]
    wire div_tick  = (div_r == 32'(CLK_HALF_CYC - 1));
    wire ext_rise  = pins_s.external_clock_input & ~ext_prev_r;
    wire ext_fall  = ~pins_s.external_clock_input & ext_prev_r;
    wire rise_src  = pins_s.ext_clk_sel ? ext_rise : div_tick;
    wire fall_src  = pins_s.ext_clk_sel ? ext_fall : div_tick;

    // Clock keeps running through the done check and the user-mode tail [RL2]
    wire clk_run   = (state_r == S_STREAM && stage_v_r) || state_r == S_CHECK
                     || (state_r == S_USER && edge_r < 8'(USER_CYC));
    wire do_rise   = clk_run && rise_src && !config_clock_out;
    wire do_fall   = fall_src && config_clock_out;
    wire ship      = do_rise && state_r == S_STREAM;
    wire take      = src_valid && src_ready;
    wire eval      = pend_r && since_r == 2'(TRE_CYC);
    wire abort_end = state_r == S_ABORT && state_nxt == S_WAIT_HIGH;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            S_POR: begin
                if (tcnt_r >= por_lim - 32'd1)
                    state_nxt = S_WAIT_HIGH;
            end
            S_WAIT_HIGH: begin
                if (hold_hi)
                    state_nxt = S_SETUP; // [RL12]
            end
            S_SETUP: begin
                if (!hold_hi)
                    state_nxt = S_ABORT;
                else if (tcnt_r == 32'(TCE_CYC - 1))
                    state_nxt = S_STREAM; // [RL4] [RL5]
            end
            S_STREAM: begin
                if (!hold_hi)
                    state_nxt = S_ABORT;
                else if (ship && stage_r.last)
                    state_nxt = S_CHECK;
            end
            S_CHECK: begin
                if (!hold_hi)
                    state_nxt = S_ABORT;
                else if (eval && done_hi)
                    state_nxt = S_USER;
                else if (eval && edge_r >= 8'(CHECK_EDGES))
                    state_nxt = S_ERR; // [RL9]
            end
            S_USER: begin
                if (!hold_hi)
                    state_nxt = S_ABORT;
                else if (edge_r == 8'(USER_CYC) && !config_clock_out)
                    state_nxt = S_IDLE; // [RL2]
            end
            S_IDLE: begin
                if (!hold_hi)
                    state_nxt = S_ABORT;
            end
            S_ABORT: begin
                if (tcnt_r == 32'(TDF_CYC - 1))
                    state_nxt = S_WAIT_HIGH; // [RL6] [RL7]
            end
            S_ERR: begin
                if (tcnt_r == 32'(ERR_HOLD_CYC - 1))
                    state_nxt = S_WAIT_HIGH;
            end
            default: state_nxt = S_POR;
        endcase
    end

    always_comb begin
        stage_v_nxt = stage_v_r;
        if (state_r == S_ABORT)
            stage_v_nxt = 1'b0;
        else if (take)
            stage_v_nxt = 1'b1;
        else if (ship)
            stage_v_nxt = 1'b0;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r <= S_POR;
            tcnt_r  <= '0;
        end else if (clk_en) begin
            state_r <= state_nxt;
            tcnt_r  <= state_chg ? 32'd0 : tcnt_r + 32'd1; // [RL3]
        end
    end

    // Divider runs free so the first edge timing never depends on state
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            div_r      <= '0;
            ext_prev_r <= 1'b0;
        end else if (clk_en) begin
            div_r      <= div_tick ? 32'd0 : div_r + 32'd1; // [RL10]
            ext_prev_r <= pins_s.external_clock_input;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            edge_r <= '0;
        end else if (clk_en) begin
            if (state_r == S_STREAM && state_nxt == S_CHECK)
                edge_r <= 8'd1;
            else if (state_r == S_CHECK && state_nxt == S_USER)
                edge_r <= 8'd0;
            else if (do_rise && state_r != S_STREAM)
                edge_r <= edge_r + 8'd1;
        end
    end

    // Done is judged a fixed distance after a rising edge, never nearer
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            since_r <= '0;
            pend_r  <= 1'b0;
        end else if (clk_en) begin
            if (do_rise) begin
                since_r <= '0;
                pend_r  <= 1'b1;
            end else begin
                if (since_r != 2'(TRE_CYC))
                    since_r <= since_r + 2'd1;
                if (eval)
                    pend_r <= 1'b0; // [RL9]
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stage_v_r <= 1'b0;
            stage_r   <= '0;
            src_ready <= 1'b0;
        end else if (clk_en) begin
            stage_v_r <= stage_v_nxt;
            if (take)
                stage_r <= src_word;
            src_ready <= (state_nxt == S_SETUP || state_nxt == S_STREAM) && !stage_v_nxt;
        end
    end

    //--------------------------------------------------------------------------
    // Pin drivers
    //--------------------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            config_clock_out <= 1'b0;
        end else if (clk_en) begin
            if (abort_end)
                config_clock_out <= 1'b0; // [RL6]
            else if (do_rise)
                config_clock_out <= 1'b1; // [RL10]
            else if (do_fall)
                config_clock_out <= 1'b0;
        end
    end

    // Data moves with the clock's rising edge; zeros once the stream is out
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            config_data    <= '0;
            config_data_oe <= 1'b0;
        end else if (clk_en) begin
            if (abort_end || state_nxt == S_POR) begin
                config_data    <= '0;
                config_data_oe <= 1'b0; // [RL7]
            end else if (do_rise) begin
                config_data    <= ship ? stage_r.data[DATA_W-1:0] : '0; // [RL13] [RL1]
                config_data_oe <= 1'b1; // [RL5] [RL1]
            end
        end
    end

    // Open drain: the line is only ever pulled low, never driven high
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hold_line_out <= 1'b0;
            hold_line_oe  <= 1'b1;
            config_done   <= 1'b0;
            done_error    <= 1'b0;
        end else if (clk_en) begin
            hold_line_out <= 1'b0;
            hold_line_oe  <= state_nxt == S_POR || state_nxt == S_ERR; // [RL3] [RL9]
            config_done   <= state_nxt == S_IDLE;
            if (state_r == S_CHECK && state_nxt == S_ERR)
                done_error <= 1'b1;
            else if (state_r == S_WAIT_HIGH && state_nxt == S_SETUP)
                done_error <= 1'b0;
        end
    end

    //--------------------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            setup_age_r <= '0;
        else if (clk_en) begin
            if (state_r == S_WAIT_HIGH)
                setup_age_r <= '0;
            else if (setup_age_r != 32'hffffffff)
                setup_age_r <= setup_age_r + 32'd1;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_data_low_idle;
        state_r == S_IDLE |-> config_data == '0 && config_data_oe;
    endproperty
    a_data_low_idle: assert property (p_data_low_idle) else $error("data not held low"); // [RL1]

    property p_user_tail;
        state_r == S_USER && state_nxt == S_IDLE |-> edge_r == 8'(USER_CYC);
    endproperty
    a_user_tail: assert property (p_user_tail) else $error("user tail count wrong"); // [RL2]

    property p_por_hold;
        state_r == S_POR |-> hold_line_oe && !hold_line_out;
    endproperty
    a_por_hold: assert property (p_por_hold) else $error("hold line released early"); // [RL3]

    property p_first_clk;
        $rose(config_clock_out) |-> setup_age_r >= 32'(TCE_CYC);
    endproperty
    a_first_clk: assert property (p_first_clk) else $error("clock before setup time"); // [RL4]

    property p_first_data;
        $rose(config_data_oe) |-> setup_age_r >= 32'(TCE_CYC);
    endproperty
    a_first_data: assert property (p_first_data) else $error("data before setup time"); // [RL5]

    property p_clk_stop;
        abort_end && clk_en |=> !config_clock_out && state_r == S_WAIT_HIGH;
    endproperty
    a_clk_stop: assert property (p_clk_stop) else $error("clock not stopped"); // [RL6]

    property p_data_stop;
        $fell(config_data_oe) && $past(state_r) == S_ABORT |-> $past(tcnt_r) == 32'(TDF_CYC - 1);
    endproperty
    a_data_stop: assert property (p_data_stop) else $error("data stopped at wrong time"); // [RL7]

    property p_err_spacing;
        state_r == S_CHECK && state_nxt == S_ERR |-> since_r >= 2'(TRE_CYC) && !do_rise;
    endproperty
    a_err_spacing: assert property (p_err_spacing) else $error("error too near edge"); // [RL9]

    property p_wait_high;
        state_r == S_WAIT_HIGH && !hold_hi && clk_en |=> state_r == S_WAIT_HIGH;
    endproperty
    a_wait_high: assert property (p_wait_high) else $error("started while line low"); // [RL12]

    property p_data_on_rise;
        $changed(config_data) && config_data_oe && $past(config_data_oe)
            |-> $rose(config_clock_out);
    endproperty
    a_data_on_rise: assert property (p_data_on_rise) else $error("data moved off edge"); // [RL13]
endmodule // pcs_sequencer

// ### pcs_pld_model.sv
// Behavioural model of the PLD chain on the far side of the configuration stream
`timescale 1ns/1ps
module pcs_pld_model (
    input  wire logic       config_clock_out,
    input  wire logic [7:0] config_data,
    input  wire logic       config_data_oe,
    input  wire logic       hold_level,
    input  wire logic       done_enable,
    input  wire logic [7:0] expect_n,
    output logic            done_sense_input
);
    logic [7:0] rx [0:63];
    int         wcnt;
    int         rise_cnt;
    int         post_done_rises;
    realtime    first_rise_t;
    realtime    last_rise_t;
    realtime    fall_t;
    realtime    min_hi;
    realtime    min_lo;
    //--------------------------------------------------------------------------
    // Chain reset on each fall of the hold line
    //--------------------------------------------------------------------------
    task automatic clear();
        wcnt = 0;
        rise_cnt = 0;
        post_done_rises = 0;
        done_sense_input = 1'b0;
        min_hi = 1.0e9;
        min_lo = 1.0e9;
        fall_t = $realtime;
        last_rise_t = $realtime;
    endtask
    initial clear();
    always @(negedge hold_level) clear();
    //--------------------------------------------------------------------------
    // Clock phases and capture
    //--------------------------------------------------------------------------
    always @(posedge config_clock_out) begin
        if (rise_cnt == 0) first_rise_t = $realtime;
        else if ($realtime - fall_t < min_lo) min_lo = $realtime - fall_t;
        if (done_sense_input) post_done_rises++;
        rise_cnt++;
        last_rise_t = $realtime;
    end
    // Data stands from one rise to the next, so the fall is the safe place to look
    always @(negedge config_clock_out) begin
        if ($realtime - last_rise_t < min_hi) min_hi = $realtime - last_rise_t;
        fall_t = $realtime;
        if (config_data_oe && !done_sense_input && wcnt < 64) begin
            rx[wcnt] = config_data;
            wcnt++;
        end
        if (done_enable && wcnt == int'(expect_n)) done_sense_input = 1'b1;
    end
endmodule // pcs_pld_model

// ### pcs_sequencer_test.sv
// Self-checking testbench of the configuration stream sequencer
`timescale 1ns/1ps
module pcs_sequencer_test;
    import pcs_pkg::*;
    localparam int USER_N = 10;
    logic       ref_clk;
    logic       rst;
    logic       clk_en;
    logic       por_long_sel;
    logic       ext_clk_sel;
    logic       external_clock_input;
    logic       tb_pull;
    logic       src_valid;
    logic       done_enable;
    pcs_word_t  src_word;
    logic [7:0] expect_n;
    logic       src_ready;
    logic       config_clock_out;
    logic [7:0] config_data;
    logic       config_data_oe;
    logic       hold_line_out;
    logic       hold_line_oe;
    logic       config_done;
    logic       done_error;
    logic       done_sense_input;
    int         err_total;
    int         n_compared;
    int         c;
    realtime    hold_high_t;
    realtime    oe_t;
    realtime    rise_t;
    realtime    pull_t;
    // Open-drain hold line with its pull-up
    wire hold_level = (hold_line_oe ? hold_line_out : 1'b1) & ~tb_pull;

    pcs_sequencer #(.POR_SHORT_CYC(20), .POR_LONG_CYC(50), .USER_CYC(USER_N)) dut (
        .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .por_long_sel(por_long_sel),
        .ext_clk_sel(ext_clk_sel), .external_clock_input(external_clock_input),
        .hold_line_in(hold_level), .done_sense_input(done_sense_input),
        .src_valid(src_valid), .src_word(src_word), .src_ready(src_ready),
        .config_clock_out(config_clock_out), .config_data(config_data),
        .config_data_oe(config_data_oe), .hold_line_out(hold_line_out),
        .hold_line_oe(hold_line_oe), .config_done(config_done), .done_error(done_error));
    pcs_pld_model pld (
        .config_clock_out(config_clock_out), .config_data(config_data),
        .config_data_oe(config_data_oe), .hold_level(hold_level),
        .done_enable(done_enable), .expect_n(expect_n), .done_sense_input(done_sense_input));
    //--------------------------------------------------------------------------
    // Clocks and timestamps
    //--------------------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // Free-running source far below the fastest allowed input clock
    initial begin
        external_clock_input = 1'b0;
        forever #100 external_clock_input = ~external_clock_input;
    end
    always @(posedge hold_level) hold_high_t = $realtime;
    always @(posedge config_data_oe) oe_t = $realtime;
    // The chain model restarts its own timestamps when the line drops, so keep ours
    always @(posedge config_clock_out) rise_t = $realtime;
    always @(posedge hold_line_oe) pull_t = $realtime;
    //--------------------------------------------------------------------------
    // Shared tasks
    //--------------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic do_reset(input logic sel, input logic [7:0] n);
        @(negedge ref_clk);
        rst = 1'b1;
        por_long_sel = sel;
        src_valid = 1'b0;
        expect_n = n;
        repeat (10) @(negedge ref_clk);
        rst = 1'b0;
    endtask
    // One word per accepted cycle; words are held until src_ready is seen
    task automatic send(input int n, input logic [7:0] base, input logic fin);
        for (int i = 0; i < n; i++) begin
            src_valid = 1'b1;
            src_word.last = fin && (i == n - 1);
            src_word.data = base + 8'(i);
            for (int k = 0; k < 20000 && !src_ready; k++) @(negedge ref_clk);
            @(negedge ref_clk);
        end
        src_valid = 1'b0;
    endtask
    task automatic wait_done();
        for (c = 0; c < 4000 && config_done !== 1'b1; c++) @(negedge ref_clk);
    endtask
    //--------------------------------------------------------------------------
    // Scenarios
    //--------------------------------------------------------------------------
    task automatic t_por(input logic sel, input int n);
        do_reset(sel, 8'h04);
        // Ten frozen cycles must stretch the hold by at least as much and at most four cycles more
        clk_en = 1'b0;
        repeat (10) @(negedge ref_clk);
        clk_en = 1'b1;
        for (c = 10; c < 210 && hold_line_oe === 1'b1; c++) @(negedge ref_clk);
        check(32'(c >= n + 10 && c <= n + 14), 32'h1);
        $display("test power-on hold %0d finished", n);
    endtask
    // Line held low from outside past the power-on hold, then a wrapping stream
    task automatic t_stream();
        do_reset(1'b0, 8'h04);
        tb_pull = 1'b1;
        repeat (120) @(negedge ref_clk);
        check({31'h0, src_ready}, 32'h0);
        check(32'(pld.rise_cnt), 32'h0);
        tb_pull = 1'b0;
        send(4, 8'hfe, 1'b1);
        wait_done();
        check(32'(pld.first_rise_t - hold_high_t >= 40000.0), 32'h1);
        check(32'(oe_t - hold_high_t >= 40000.0), 32'h1);
        for (int i = 0; i < 4; i++) check({24'h0, pld.rx[i]}, {24'h0, 8'hfe + 8'(i)});
        check(32'(pld.post_done_rises >= USER_N && pld.post_done_rises <= USER_N + 3), 32'h1);
        check(32'(pld.min_hi >= 6.0 && pld.min_lo >= 6.0), 32'h1);
        check(32'(pld.min_hi + pld.min_lo >= 15.0), 32'h1);
        c = pld.rise_cnt;
        repeat (20) @(negedge ref_clk);
        check({22'h0, config_done, config_data_oe, config_data}, {22'h0, 2'b11, 8'h00});
        check(32'(pld.rise_cnt), 32'(c));
        $display("test stream finished");
    endtask
    // Short outside pulse on the hold line in mid-stream
    task automatic t_abort();
        do_reset(1'b0, 8'h40);
        fork : feeder
            send(30, 8'h10, 1'b0);
        join_none
        for (c = 0; c < 4000 && pld.rise_cnt < 3; c++) @(negedge ref_clk);
        tb_pull = 1'b1;
        repeat (3) @(negedge ref_clk);
        tb_pull = 1'b0;
        for (c = 3; c < 60 && config_data_oe === 1'b1; c++) @(negedge ref_clk);
        disable feeder;
        src_valid = 1'b0;
        check(32'(c >= 12 && c <= 20), 32'h1);
        check({31'h0, config_clock_out}, 32'h0);
        check(32'(pld.rise_cnt <= 1), 32'h1);
        $display("test abort finished");
    endtask
    // No done from the chain: error pulse on the hold line, then recovery
    task automatic t_error();
        do_reset(1'b0, 8'h03);
        done_enable = 1'b0;
        send(3, 8'h5a, 1'b1);
        for (c = 0; c < 500 && hold_line_oe !== 1'b1; c++) @(negedge ref_clk);
        check(32'(pull_t - rise_t >= 60.0), 32'h1);
        check({31'h0, done_error}, 32'h1);
        done_enable = 1'b1;
        for (c = 0; c < 50 && hold_line_oe === 1'b1; c++) @(negedge ref_clk);
        check(32'(c), 32'h4);
        repeat (10) @(negedge ref_clk);
        check({31'h0, done_error}, 32'h0);
        $display("test done error finished");
    endtask
    task automatic t_ext();
        do_reset(1'b0, 8'h03);
        ext_clk_sel = 1'b1;
        send(3, 8'hc3, 1'b1);
        wait_done();
        for (int i = 0; i < 3; i++) check({24'h0, pld.rx[i]}, {24'h0, 8'hc3 + 8'(i)});
        check(32'(pld.min_hi + pld.min_lo >= 150.0), 32'h1);
        check({31'h0, config_done}, 32'h1);
        ext_clk_sel = 1'b0;
        $display("test external clock finished");
    endtask
    //--------------------------------------------------------------------------
    // Main sequence and watchdog
    //--------------------------------------------------------------------------
    initial begin
        rst = 1'b1;
        clk_en = 1'b1;
        por_long_sel = 1'b0;
        ext_clk_sel = 1'b0;
        tb_pull = 1'b0;
        src_valid = 1'b0;
        src_word = '0;
        done_enable = 1'b1;
        expect_n = 8'h04;
        err_total = 0;
        n_compared = 0;
        t_por(1'b1, 50);
        t_por(1'b0, 20);
        t_stream();
        t_abort();
        t_error();
        t_ext();
        summarize();
    end
    // Whole run needs well under 0.5 ms
    initial begin
        #2000000;
        err_total++;
        $display("watchdog expired");
        summarize();
    end
endmodule // pcs_sequencer_test
